// ===== rps_pkg.sv
// constants and helpers shared by the reference prescaler files
package rps_pkg;

  localparam int unsigned NUM_REF     = 4;
  localparam int unsigned ADDR_W      = 8;
  localparam int unsigned DATA_W      = 32;
  localparam int unsigned RATIO_W     = 20;
  localparam int unsigned IDX_W       = 2;

  // register map, one aligned word each
  localparam logic [7:0]  CFG_BASE_OFF   = 8'h00;
  localparam logic [7:0]  CFG_STRIDE     = 8'h04;
  localparam logic [7:0]  STATUS_OFF     = 8'h10;
  localparam logic [7:0]  SELECT_OFF     = 8'h14;

  // reference_prescale_config field positions
  localparam int unsigned PRIO_BIT       = 24;
  localparam int unsigned SETB_BIT       = 22;
  localparam int unsigned ENB_BIT        = 21;
  localparam int unsigned BYP_BIT        = 20;
  localparam int unsigned RATIO_LSB      = 0;

  // reset value: released, enabled, bypassed, ratio zero
  localparam logic [31:0] CFG_RST        = 32'h0050_0000;
  // writable bits; reserved bits stay zero
  localparam logic [31:0] CFG_WMASK      = 32'h017f_ffff;

  // status word field positions
  localparam int unsigned ST_LEVEL_LSB   = 0;
  localparam int unsigned ST_RUN_LSB     = 4;
  localparam int unsigned ST_BAD_LSB     = 8;
  localparam int unsigned ST_SEL_LSB     = 12;
  localparam int unsigned ST_VALID_BIT   = 16;

  localparam logic [RATIO_W-1:0] DIV_MIN = 20'h0_0002;
  localparam logic [31:0]        RDATA_RST = 32'h0000_0000;

  // the divisor actually used; anything under the minimum is raised to it
  function automatic logic [RATIO_W-1:0] eff_divisor(input logic [RATIO_W-1:0] r);
    eff_divisor = (r < DIV_MIN) ? DIV_MIN : r;
  endfunction : eff_divisor

  function automatic logic ratio_bad(input logic [RATIO_W-1:0] r);
    ratio_bad = (r < DIV_MIN);
  endfunction : ratio_bad

endpackage : rps_pkg

// ===== rps_divider.sv
// one reference prescaler channel: synchroniser, divider and bypass
`timescale 1ns/1ps
module rps_divider
  import rps_pkg::*;
(
  input  wire logic               core_clk,
  input  wire logic               rst_b,
  input  wire logic               ref_pin,
  input  wire logic               release_set_b,
  input  wire logic               enable_b,
  input  wire logic               prescaler_bypass,
  input  wire logic [RATIO_W-1:0] prescale_divisor,
  output logic                    clk_out,
  output logic                    running
);

  typedef enum logic [2:0]
  {
    ST_HOLD = 3'b001,
    ST_OFF  = 3'b010,
    ST_RUN  = 3'b100
  } rps_div_state_t;

  logic                 sync1_r;
  logic                 sync2_r;
  logic                 prev_r;
  logic [RATIO_W-1:0]   cnt_r;
  logic [RATIO_W-1:0]   cnt_nxt;
  logic                 out_r;
  logic                 out_nxt;
  rps_div_state_t       state_r;
  rps_div_state_t       state_nxt;
  logic                 rise;
  logic [RATIO_W-1:0]   div_eff;

  ////////////////////////////////////////////////////////////////////////////
  // pin synchroniser; only sync2_r and later stages are looked at

  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
      prev_r  <= 1'b0;
    end
    else
    begin
      sync1_r <= ref_pin;
      sync2_r <= sync1_r;
      prev_r  <= sync2_r;
    end
  end

  assign rise    = sync2_r & ~prev_r;
  assign div_eff = eff_divisor(prescale_divisor);

  ////////////////////////////////////////////////////////////////////////////
  // state, count and output level

  always_comb
  begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    out_nxt   = out_r;
    if (!release_set_b)
      state_nxt = ST_HOLD;
    else if (enable_b)
      state_nxt = ST_OFF;
    else
      state_nxt = ST_RUN;
    case (state_nxt)
      ST_RUN:
      begin
        if (prescaler_bypass)
        begin
          cnt_nxt = '0;
          out_nxt = sync2_r;
        end
        else if (rise)
        begin
          cnt_nxt = (cnt_r >= div_eff - 20'h0_0001) ? '0 : cnt_r + 20'h0_0001;
          out_nxt = (cnt_nxt < (div_eff >> 1));
        end
      end
      default:
      begin
        // held or disabled: static low, counter parked
        cnt_nxt = '0;
        out_nxt = 1'b0;
      end
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      state_r <= ST_RUN;
      cnt_r   <= '0;
      out_r   <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
      out_r   <= out_nxt;
    end
  end

  assign clk_out = out_r;
  assign running = (state_r == ST_RUN);

endmodule : rps_divider

// ===== rps_prescaler_top.sv
// reference input prescalers with register port and rank-based selection
//
// Contract
// - each input carries one rank bit; zero is first rank, one second rank.
// - equal rank inputs are preferred lowest index first, up to input three.
// - hold bit at 22 cleared keeps the prescaler in set; one releases it.
// - enable bit at 21 is active low; one disables the prescaler.
// - bypass bit 20 zero routes reference divided by programmed divisor, or by two if it is under two.
// - bypass bit one passes the reference undivided, effective division one.
// - prescaler output feeds both the digital phase loop and the monitor.
`timescale 1ns/1ps
module rps_prescaler_top
  import rps_pkg::*;
(
  input  wire logic                       core_clk,
  input  wire logic                       rst_b,
  input  wire logic [rps_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic [rps_pkg::DATA_W-1:0] reg_wdata,
  input  wire logic                       reg_wr,
  input  wire logic                       reg_rd,
  output logic      [rps_pkg::DATA_W-1:0] reg_rdata,
  input  wire logic [rps_pkg::NUM_REF-1:0] reference_input,
  input  wire logic [rps_pkg::NUM_REF-1:0] ref_qualified,
  output logic      [rps_pkg::NUM_REF-1:0] digital_phase_loop_ref,
  output logic      [rps_pkg::NUM_REF-1:0] monitor_ref,
  output logic                            sel_valid,
  output logic      [rps_pkg::IDX_W-1:0]   sel_index,
  output logic                            sel_ref_clk
);

  import rps_pkg::*;

  logic [DATA_W-1:0]   cfg_r     [NUM_REF];
  logic [DATA_W-1:0]   cfg_nxt   [NUM_REF];
  logic [DATA_W-1:0]   rdata_r;
  logic [DATA_W-1:0]   rdata_nxt;
  logic [NUM_REF-1:0]  lvl;
  logic [NUM_REF-1:0]  run;
  logic [NUM_REF-1:0]  bad;
  logic [NUM_REF-1:0]  rank;
  logic                sel_valid_r;
  logic                sel_valid_nxt;
  logic [IDX_W-1:0]    sel_index_r;
  logic [IDX_W-1:0]    sel_index_nxt;
  logic                sel_clk_r;
  logic                sel_clk_nxt;
  logic [DATA_W-1:0]   status_word;
  logic [DATA_W-1:0]   select_word;

  ////////////////////////////////////////////////////////////////////////////
  // address decode helpers

  function automatic logic is_cfg(input logic [ADDR_W-1:0] a);
    is_cfg = (a >= CFG_BASE_OFF) && (a < STATUS_OFF) && (a[1:0] == 2'b00);
  endfunction : is_cfg

  function automatic logic [IDX_W-1:0] cfg_idx(input logic [ADDR_W-1:0] a);
    logic [ADDR_W-1:0] d;
    d       = a - CFG_BASE_OFF;
    cfg_idx = d[IDX_W+1:2];
  endfunction : cfg_idx

  // rank 0 before rank 1, then lowest index within a rank
  function automatic logic [IDX_W:0] pick_ref(input logic [NUM_REF-1:0] q,
                                              input logic [NUM_REF-1:0] rk);
    logic             found;
    logic [IDX_W-1:0] idx;
    found = 1'b0;
    idx   = '0;
    for (int p = 1; p >= 0; p--)
    begin
      for (int i = NUM_REF - 1; i >= 0; i--)
      begin
        if (q[i] && (rk[i] == p[0]))
        begin
          found = 1'b1;
          idx   = i[IDX_W-1:0];
        end
      end
      if (found && (p == 0))
        break;
    end
    pick_ref = {found, idx};
  endfunction : pick_ref

  ////////////////////////////////////////////////////////////////////////////
  // configuration registers

  always_comb
  begin
    for (int i = 0; i < NUM_REF; i++)
      cfg_nxt[i] = cfg_r[i];
    if (reg_wr && is_cfg(reg_addr))
      cfg_nxt[cfg_idx(reg_addr)] = reg_wdata & CFG_WMASK;
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      for (int i = 0; i < NUM_REF; i++)
        cfg_r[i] <= CFG_RST;
    end
    else
    begin
      for (int i = 0; i < NUM_REF; i++)
        cfg_r[i] <= cfg_nxt[i];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // prescaler channels

  for (genvar g = 0; g < NUM_REF; g++)
  begin : g_ch
    rps_divider u_div
    (
      .core_clk         (core_clk),
      .rst_b            (rst_b),
      .ref_pin          (reference_input[g]),
      .release_set_b    (cfg_r[g][SETB_BIT]),
      .enable_b         (cfg_r[g][ENB_BIT]),
      .prescaler_bypass (cfg_r[g][BYP_BIT]),
      .prescale_divisor (cfg_r[g][RATIO_LSB +: RATIO_W]),
      .clk_out          (lvl[g]),
      .running          (run[g])
    );
    assign rank[g] = cfg_r[g][PRIO_BIT];
    // flags a divisor under two while dividing; the divider uses two then
    assign bad[g]  = ~cfg_r[g][BYP_BIT] & ratio_bad(cfg_r[g][RATIO_LSB +: RATIO_W]);
  end

  // one registered level fans out to both consumers, so they never disagree
  assign digital_phase_loop_ref = lvl;
  assign monitor_ref            = lvl;

  ////////////////////////////////////////////////////////////////////////////
  // reference selection for the loop

  always_comb
  begin
    logic [IDX_W:0] pk;
    pk            = pick_ref(ref_qualified, rank);
    sel_valid_nxt = pk[IDX_W];
    sel_index_nxt = pk[IDX_W-1:0];
    // without a qualified input the selected clock is parked low
    sel_clk_nxt   = pk[IDX_W] ? lvl[pk[IDX_W-1:0]] : 1'b0;
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      sel_valid_r <= 1'b0;
      sel_index_r <= '0;
      sel_clk_r   <= 1'b0;
    end
    else
    begin
      sel_valid_r <= sel_valid_nxt;
      sel_index_r <= sel_index_nxt;
      sel_clk_r   <= sel_clk_nxt;
    end
  end

  assign sel_valid   = sel_valid_r;
  assign sel_index   = sel_index_r;
  assign sel_ref_clk = sel_clk_r;

  ////////////////////////////////////////////////////////////////////////////
  // read path; unmapped addresses read zero, data one cycle after the strobe

  always_comb
  begin
    status_word                                = '0;
    status_word[ST_LEVEL_LSB +: NUM_REF]       = lvl;
    status_word[ST_RUN_LSB +: NUM_REF]         = run;
    status_word[ST_BAD_LSB +: NUM_REF]         = bad;
    status_word[ST_SEL_LSB +: IDX_W]           = sel_index_r;
    status_word[ST_VALID_BIT]                  = sel_valid_r;
    select_word                                = '0;
    select_word[NUM_REF-1:0]                   = rank;
    select_word[ST_LEVEL_LSB+8 +: NUM_REF]     = ref_qualified;
  end

  always_comb
  begin
    rdata_nxt = '0;
    if (reg_rd)
    begin
      if (is_cfg(reg_addr))
        rdata_nxt = cfg_r[cfg_idx(reg_addr)];
      else if (reg_addr == STATUS_OFF)
        rdata_nxt = status_word;
      else if (reg_addr == SELECT_OFF)
        rdata_nxt = select_word;
      else
        rdata_nxt = '0;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
      rdata_r <= RDATA_RST;
    else
      rdata_r <= rdata_nxt;
  end

  assign reg_rdata = rdata_r;

endmodule : rps_prescaler_top

// ===== rps_ref_src.sv
// reference clock source model driving the four reference pins
`timescale 1ns/1ps
module rps_ref_src
  import rps_pkg::*;
(
  output logic [rps_pkg::NUM_REF-1:0] ref_clk
);
  // free running, all under 33 MHz so bypass stays legal
  // half periods off the core grid so the phase drifts
  initial ref_clk = 4'h0;
  always #21.3 ref_clk[0] = ~ref_clk[0];
  always #26.1 ref_clk[1] = ~ref_clk[1];
  always #33.7 ref_clk[2] = ~ref_clk[2];
  always #41.9 ref_clk[3] = ~ref_clk[3];
endmodule : rps_ref_src

// ===== rps_prescaler_top_monitor.sv
// checker on the prescaler top ports
`timescale 1ns/1ps
module rps_prescaler_top_monitor
  import rps_pkg::*;
(
  input wire logic                        core_clk,
  input wire logic                        rst_b,
  input wire logic [rps_pkg::ADDR_W-1:0]  reg_addr,
  input wire logic [rps_pkg::DATA_W-1:0]  reg_wdata,
  input wire logic                        reg_wr,
  input wire logic                        reg_rd,
  input wire logic [rps_pkg::DATA_W-1:0]  reg_rdata,
  input wire logic [rps_pkg::NUM_REF-1:0] reference_input,
  input wire logic [rps_pkg::NUM_REF-1:0] ref_qualified,
  input wire logic [rps_pkg::NUM_REF-1:0] digital_phase_loop_ref,
  input wire logic [rps_pkg::NUM_REF-1:0] monitor_ref,
  input wire logic                        sel_valid,
  input wire logic [rps_pkg::IDX_W-1:0]   sel_index,
  input wire logic                        sel_ref_clk
);
  // shadow of channel 0 config, only what the checks need
  logic held0_r, held0_nxt, rank0_r, rank0_nxt;
  always_comb
  begin
    held0_nxt = held0_r;
    rank0_nxt = rank0_r;
    if (reg_wr && reg_addr == 8'h00)
    begin
      held0_nxt = !reg_wdata[22] || reg_wdata[21];
      rank0_nxt = reg_wdata[24];
    end
  end
  always_ff @(posedge core_clk)
  begin
    held0_r <= rst_b ? held0_nxt : 1'b0;
    rank0_r <= rst_b ? rank0_nxt : 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_b);
  sequence s_qual_seen;
    ref_qualified != 4'h0;
  endsequence
  sequence s_pick;
    sel_valid && ((($past(ref_qualified) >> sel_index) & 4'h1) != 4'h0);
  endsequence
  AST_MON_COPY: assert property (monitor_ref == digital_phase_loop_ref)
    else $error("monitor copy differs from loop reference");
  AST_SEL_ANY: assert property (s_qual_seen |=> s_pick)
    else $error("selection missed a qualified input");
  AST_SEL_NONE: assert property ((ref_qualified == 4'h0) [*2] |=> !sel_valid && !sel_ref_clk)
    else $error("selection valid with no qualified input");
  AST_SEL_FIRST: assert property (ref_qualified[0] && !rank0_r |=> sel_valid && sel_index == 2'd0)
    else $error("first rank input zero not chosen");
  AST_SEL_CLK: assert property (sel_valid && $past(sel_valid) && $stable(sel_index)
    |-> sel_ref_clk == $past(digital_phase_loop_ref[sel_index]))
    else $error("selected clock does not follow chosen channel");
  AST_HOLD_STATIC: assert property (held0_r |=> !digital_phase_loop_ref[0])
    else $error("held channel output not low");
  AST_MON_HOLD: assert property (held0_r |=> !monitor_ref[0])
    else $error("held channel monitor output not low");
  AST_NO_RISE_HELD: assert property ($rose(digital_phase_loop_ref[0]) |-> !$past(held0_r))
    else $error("held channel produced an edge");
endmodule : rps_prescaler_top_monitor

bind rps_prescaler_top rps_prescaler_top_monitor rps_prescaler_top_monitor_i (
  .core_clk(core_clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .reference_input(reference_input), .ref_qualified(ref_qualified),
  .digital_phase_loop_ref(digital_phase_loop_ref), .monitor_ref(monitor_ref),
  .sel_valid(sel_valid), .sel_index(sel_index), .sel_ref_clk(sel_ref_clk));

// ===== rps_prescaler_top_tb.sv
// self-checking bench for the reference prescaler top
`timescale 1ns/1ps
module rps_prescaler_top_tb;
  import rps_pkg::*;
  typedef struct {logic [31:0] cfg; int n; logic [1:0] st;} rps_row_t;
  logic               core_clk, rst_b, reg_wr, reg_rd, p_q, o_q, cnt_en;
  logic               sel_valid, sel_ref_clk;
  logic [ADDR_W-1:0]  reg_addr;
  logic [DATA_W-1:0]  reg_wdata, reg_rdata;
  logic [NUM_REF-1:0] reference_input, ref_qualified, dpl_ref, mon_ref;
  logic [IDX_W-1:0]   sel_index;
  int                 failures, num_checks, p_cnt, o_cnt, d;
  // cfg word, expected divisor (0 means no edges), {bad, running}
  rps_row_t rows [7] = '{
    '{32'h0050_0000, 1, 2'b01},
    '{32'h0040_0002, 2, 2'b01},
    '{32'h0040_0003, 3, 2'b01},
    '{32'h0040_0005, 5, 2'b01},
    '{32'h0040_0000, 2, 2'b11},
    '{32'h0000_0003, 0, 2'b00},
    '{32'h0060_0003, 0, 2'b00}};
  rps_ref_src rps_ref_src_i (.ref_clk(reference_input));
  rps_prescaler_top rps_prescaler_top_i (.core_clk(core_clk), .rst_b(rst_b),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .reference_input(reference_input),
    .ref_qualified(ref_qualified), .digital_phase_loop_ref(dpl_ref),
    .monitor_ref(mon_ref), .sel_valid(sel_valid), .sel_index(sel_index),
    .sel_ref_clk(sel_ref_clk));
  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  // edge counters for channel 0 pin and output, cleared while idle
  always @(posedge core_clk)
  begin
    p_q <= reference_input[0];
    o_q <= dpl_ref[0];
    if (!cnt_en)
      p_cnt <= 0;
    else if (reference_input[0] && !p_q)
      p_cnt <= p_cnt + 1;
    if (!cnt_en)
      o_cnt <= 0;
    else if (dpl_ref[0] && !o_q)
      o_cnt <= o_cnt + 1;
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, seen);
    end
  endtask : chk
  // strobe stays up until the next call, so calls may run back to back
  task automatic bus(input logic w, input logic r, input logic [7:0] a, input logic [31:0] v);
    @(posedge core_clk);
    reg_wr <= w;
    reg_rd <= r;
    reg_addr <= a;
    reg_wdata <= v;
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    bus(1'b1, 1'b0, a, v);
    bus(1'b0, 1'b0, a, 32'h0);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    bus(1'b0, 1'b1, a, 32'h0);
    bus(1'b0, 1'b0, a, 32'h0);
    #1 q = reg_rdata;
  endtask : rd
  task automatic sel(input logic [3:0] q, input logic [2:0] e);
    @(posedge core_clk);
    ref_qualified <= q;
    repeat (2) @(posedge core_clk);
    #1 chk("selection", {sel_valid, sel_valid ? sel_index : 2'b00}, e);
  endtask : sel
  task automatic test_done;
    $display("checks %0d, failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : test_done
  ////////////////////////////////////////////////////////////////////////
  initial
  begin : main
    logic [31:0] v;
    rst_b = 1'b0;
    {reg_wr, reg_rd, cnt_en} = 3'b000;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    ref_qualified = 4'h0;
    failures = 0;
    num_checks = 0;
    repeat (10) @(posedge core_clk);
    rst_b <= 1'b1;
    @(posedge core_clk);
    #1 chk("outputs at release", {sel_valid, sel_index, sel_ref_clk, dpl_ref, mon_ref}, 0);
    for (int i = 0; i < 4; i++)
    begin
      rd(8'(4 * i), v);
      chk("config reset", v, 32'h0050_0000);
    end
    rd(8'h20, v);
    chk("unmapped read", v, 32'h0);
    foreach (rows[i])
    begin
      wr(8'h00, rows[i].cfg);
      rd(8'h10, v);
      chk("run and bad status", {v[8], v[4]}, rows[i].st);
      repeat (20) @(posedge core_clk);
      cnt_en <= 1'b1;
      repeat (600) @(posedge core_clk);
      cnt_en <= 1'b0;
      #1 d = o_cnt * rows[i].n - p_cnt;
      chk("output edge count", (rows[i].n == 0) ? (o_cnt == 0) :
          (d <= rows[i].n && d >= -rows[i].n), 1);
    end
    sel(4'b1010, 3'b101);
    wr(8'h04, 32'h0150_0000);
    sel(4'b1010, 3'b111);
    sel(4'b0011, 3'b100);
    wr(8'h00, 32'h0150_0002);
    sel(4'b0011, 3'b100);
    sel(4'b0111, 3'b110);
    sel(4'b0000, 3'b000);
    bus(1'b1, 1'b0, 8'h0c, 32'hffff_ffff);
    rd(8'h0c, v);
    chk("reserved bits dropped", v, 32'h017f_ffff);
    rd(8'h14, v);
    chk("rank bits", v, 32'h0000_000b);
    @(posedge core_clk);
    #1 chk("read data after its cycle", reg_rdata, 32'h0);
    test_done();
  end
endmodule : rps_prescaler_top_tb
